// >>> rtl/csd_exec_unit.v
// Execution unit for compare-skip and decimal-adjust instructions
//
// The address map and the strobed register port were left to the implementer.
`include "csd_defs.vh"

module csd_exec_unit
#(
   parameter QUARTER_DIV = 1,
   parameter BANK_W = 4,
   parameter [3:0] ACCESS_LO_BANK = 4'h0,
   parameter [3:0] ACCESS_HI_BANK = 4'hF
)
(
   input wire i_clock,
   input wire i_rst_b,
   input wire [2:0] i_reg_addr,
   input wire [7:0] i_reg_wdata,
   input wire i_reg_wr,
   input wire i_reg_rd,
   output reg [7:0] o_reg_rdata,
   input wire i_instr_valid,
   input wire [15:0] i_instr,
   input wire [1:0] i_next_words,
   output reg o_instr_take,
   output reg o_busy,
   output reg [11:0] o_mem_addr,
   output reg o_mem_rd,
   input wire [7:0] i_mem_rdata,
   output reg [3:0] o_quarter,
   output reg o_skip,
   output reg [1:0] o_skip_words,
   output reg o_nop_cycle,
   output reg [7:0] o_work,
   output reg o_carry
);
   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_EXEC = 3'h2;
   localparam [2:0] ST_SKIP = 3'h4;

   wire tick;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [3:0] quarter_r;
   reg [2:0] kind_r;
   reg [1:0] words_r;
   reg [1:0] skip_left_r;
   reg [7:0] opnd_r;
   reg rd_pend_r;
   reg hit_r;
   reg last_skip_r;
   reg [7:0] work_r;
   reg [BANK_W-1:0] bank_r;
   reg carry_r;
   reg digit_carry_r;
   reg ext_r;
   reg [11:0] index_r;
   reg [7:0] daw_work_r;
   reg daw_carry_r;
   wire [7:0] adj_work;
   wire adj_carry;
   wire [7:0] operand;
   wire [2:0] new_kind;
   wire take;
   wire hw_write;
   reg [7:0] rdata_nxt;
   reg [7:0] work_nxt;
   reg carry_nxt;

   // Classify an instruction word; unknown words yield none
   function [2:0] decode_kind;
      input [15:0] word;
      begin
         if (word[15:`CSD_OPC_HI_LSB] == `CSD_OPC_CMP_LT)
            decode_kind = `CSD_K_LT;
         else if (word[15:`CSD_OPC_HI_LSB] == `CSD_OPC_CMP_GT)
            decode_kind = `CSD_K_GT;
         else if (word == `CSD_OPC_DAW)
            decode_kind = `CSD_K_DAW;
         else
            decode_kind = `CSD_K_NONE;
      end
   endfunction

   // Data memory address of the file operand
   function [11:0] file_addr;
      input [7:0] f;
      input a;
      input ext;
      input [BANK_W-1:0] bank;
      input [11:0] index;
      reg [11:0] bank_ext;
      begin
         bank_ext = 12'h000;
         bank_ext[BANK_W-1:0] = bank;
         if (!a && ext && f <= `CSD_ILO_LIMIT)
            file_addr = index + {4'h0, f};
         else if (a)
            file_addr = {bank_ext[3:0], f};
         else if (f < `CSD_ACC_SPLIT)
            file_addr = {ACCESS_LO_BANK, f};
         else
            file_addr = {ACCESS_HI_BANK, f};
      end
   endfunction

   csd_quarter_div #(
      .DIV(QUARTER_DIV)
   ) u_div (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .o_tick(tick)
   );

   csd_bcd_adjust u_adj (
      .i_work(work_r),
      .i_carry(carry_r),
      .i_digit_carry(digit_carry_r),
      .o_work(adj_work),
      .o_carry(adj_carry)
   );

   assign new_kind = decode_kind(i_instr);
   assign take = tick && state_r == ST_IDLE && quarter_r == `CSD_Q1 && i_instr_valid && new_kind != `CSD_K_NONE;
   // Read data stands only in the cycle after the strobe
   assign operand = rd_pend_r ? i_mem_rdata : opnd_r;
   assign hw_write = tick && state_r == ST_EXEC && quarter_r == `CSD_Q4 && kind_r == `CSD_K_DAW;

   // Sequencer: one instruction cycle is four quarters
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
         begin
            if (take)
               state_nxt = ST_EXEC;
         end
         ST_EXEC:
         begin
            if (tick && quarter_r == `CSD_Q4)
               state_nxt = (kind_r != `CSD_K_DAW && hit_r) ? ST_SKIP : ST_IDLE;
         end
         ST_SKIP:
         begin
            if (tick && quarter_r == `CSD_Q4 && skip_left_r == 2'h1)
               state_nxt = ST_IDLE;
         end
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         state_r <= ST_IDLE;
         quarter_r <= `CSD_Q1;
         kind_r <= `CSD_K_NONE;
         words_r <= 2'h1;
         skip_left_r <= 2'h0;
         hit_r <= 1'b0;
         last_skip_r <= 1'b0;
         daw_work_r <= 8'h00;
         daw_carry_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         if (tick)
            quarter_r <= {quarter_r[2:0], quarter_r[3]};
         if (take)
         begin
            kind_r <= new_kind;
            words_r <= (i_next_words == 2'h0) ? 2'h1 : i_next_words;
         end
         if (tick && state_r == ST_EXEC && quarter_r == `CSD_Q3)
         begin
            // Unsigned compare; flags stay as they are
            if (kind_r == `CSD_K_LT)
               hit_r <= operand < work_r;
            else if (kind_r == `CSD_K_GT)
               hit_r <= operand > work_r;
            else
               hit_r <= 1'b0;
            daw_work_r <= adj_work;
            daw_carry_r <= adj_carry;
         end
         if (tick && state_r == ST_EXEC && quarter_r == `CSD_Q4)
         begin
            last_skip_r <= kind_r != `CSD_K_DAW && hit_r;
            skip_left_r <= words_r;
         end
         else if (tick && state_r == ST_SKIP && quarter_r == `CSD_Q4)
            skip_left_r <= skip_left_r - 2'h1;
      end
   end

   // Operand fetch: address at decode, read strobe during Q2
   always @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         o_mem_addr <= 12'h000;
         o_mem_rd <= 1'b0;
         rd_pend_r <= 1'b0;
         opnd_r <= 8'h00;
      end
      else
      begin
         o_mem_rd <= take && new_kind != `CSD_K_DAW;
         if (take && new_kind != `CSD_K_DAW)
            o_mem_addr <= file_addr(i_instr[7:0], i_instr[`CSD_A_BIT], ext_r, bank_r, index_r);
         rd_pend_r <= o_mem_rd;
         if (rd_pend_r)
            opnd_r <= i_mem_rdata;
      end
   end

   // Next work and carry; the outputs mirror these, so they never lag a write
   always @*
   begin
      work_nxt = work_r;
      carry_nxt = carry_r;
      if (hw_write)
         work_nxt = daw_work_r;
      else if (i_reg_wr && i_reg_addr == `CSD_REG_WORK)
         work_nxt = i_reg_wdata;
      if (i_reg_wr && i_reg_addr == `CSD_REG_FLAGS)
         carry_nxt = i_reg_wdata[`CSD_FLAG_C];
      // Set from the adjust wins over a clear in the same cycle
      if (hw_write)
         carry_nxt = carry_nxt | daw_carry_r;
   end

   // Software registers; the unit's own write to work wins
   always @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         work_r <= 8'h00;
         bank_r <= {BANK_W{1'b0}};
         carry_r <= 1'b0;
         digit_carry_r <= 1'b0;
         ext_r <= 1'b0;
         index_r <= 12'h000;
      end
      else
      begin
         work_r <= work_nxt;
         if (i_reg_wr && i_reg_addr == `CSD_REG_BANK)
            bank_r <= i_reg_wdata[BANK_W-1:0];
         carry_r <= carry_nxt;
         if (i_reg_wr && i_reg_addr == `CSD_REG_FLAGS)
            digit_carry_r <= i_reg_wdata[`CSD_FLAG_DC];
         if (i_reg_wr && i_reg_addr == `CSD_REG_CTRL)
            ext_r <= i_reg_wdata[`CSD_CTRL_EXT];
         if (i_reg_wr && i_reg_addr == `CSD_REG_IDX_LO)
            index_r[7:0] <= i_reg_wdata;
         if (i_reg_wr && i_reg_addr == `CSD_REG_IDX_HI)
            index_r[11:8] <= i_reg_wdata[3:0];
      end
   end

   always @*
   begin
      rdata_nxt = 8'h00;
      case (i_reg_addr)
         `CSD_REG_WORK: rdata_nxt = work_r;
         `CSD_REG_BANK: rdata_nxt[BANK_W-1:0] = bank_r;
         `CSD_REG_FLAGS:
         begin
            rdata_nxt[`CSD_FLAG_C] = carry_r;
            rdata_nxt[`CSD_FLAG_DC] = digit_carry_r;
         end
         `CSD_REG_CTRL: rdata_nxt[`CSD_CTRL_EXT] = ext_r;
         `CSD_REG_IDX_LO: rdata_nxt = index_r[7:0];
         `CSD_REG_IDX_HI: rdata_nxt[3:0] = index_r[11:8];
         `CSD_REG_EXEC:
         begin
            rdata_nxt[`CSD_EXEC_BUSY] = state_r != ST_IDLE;
            rdata_nxt[`CSD_EXEC_SKIP] = last_skip_r;
            rdata_nxt[`CSD_EXEC_WORDS_LSB+1:`CSD_EXEC_WORDS_LSB] = words_r;
         end
         default: rdata_nxt = 8'h00;
      endcase
   end

   // Every output registered
   always @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         o_reg_rdata <= 8'h00;
         o_instr_take <= 1'b0;
         o_busy <= 1'b0;
         o_quarter <= `CSD_Q1;
         o_skip <= 1'b0;
         o_skip_words <= 2'h0;
         o_nop_cycle <= 1'b0;
         o_work <= 8'h00;
         o_carry <= 1'b0;
      end
      else
      begin
         if (i_reg_rd)
            o_reg_rdata <= rdata_nxt;
         else
            o_reg_rdata <= 8'h00;
         o_instr_take <= take;
         o_busy <= state_nxt != ST_IDLE;
         o_quarter <= tick ? {quarter_r[2:0], quarter_r[3]} : quarter_r;
         // Fetched word is discarded; core runs no-operation cycles
         o_skip <= tick && state_r == ST_EXEC && quarter_r == `CSD_Q4 && kind_r != `CSD_K_DAW && hit_r;
         if (tick && state_r == ST_EXEC && quarter_r == `CSD_Q4)
            o_skip_words <= (kind_r != `CSD_K_DAW && hit_r) ? words_r : 2'h0;
         o_nop_cycle <= state_nxt == ST_SKIP;
         o_work <= work_nxt;
         o_carry <= carry_nxt;
      end
   end
endmodule // csd_exec_unit

// >>> rtl/csd_defs.vh
// Constants for the compare-skip and decimal-adjust execution unit
`ifndef CSD_DEFS_VH
`define CSD_DEFS_VH

`define CSD_OPC_HI_LSB 9
`define CSD_OPC_CMP_LT 7'h30
`define CSD_OPC_CMP_GT 7'h32
`define CSD_OPC_DAW 16'h0007
`define CSD_A_BIT 8

`define CSD_ILO_LIMIT 8'h5F
`define CSD_ACC_SPLIT 8'h60

`define CSD_BCD_MAX 5'h09
`define CSD_BCD_FIX 5'h06

`define CSD_REG_WORK 3'h0
`define CSD_REG_BANK 3'h1
`define CSD_REG_FLAGS 3'h2
`define CSD_REG_CTRL 3'h3
`define CSD_REG_IDX_LO 3'h4
`define CSD_REG_IDX_HI 3'h5
`define CSD_REG_EXEC 3'h6

`define CSD_FLAG_C 0
`define CSD_FLAG_DC 1
`define CSD_CTRL_EXT 0
`define CSD_EXEC_BUSY 0
`define CSD_EXEC_SKIP 1
`define CSD_EXEC_WORDS_LSB 2

`define CSD_Q1 4'h1
`define CSD_Q2 4'h2
`define CSD_Q3 4'h4
`define CSD_Q4 4'h8

`define CSD_K_NONE 3'h0
`define CSD_K_LT 3'h1
`define CSD_K_GT 3'h2
`define CSD_K_DAW 3'h4

`endif

// >>> rtl/csd_quarter_div.v
// Quarter-cycle enable divider
module csd_quarter_div
#(
   parameter DIV = 1
)
(
   input wire i_clock,
   input wire i_rst_b,
   output reg o_tick
);
   reg [7:0] cnt_r;

   always @(posedge i_clock)
   begin
      if (!i_rst_b)
      begin
         cnt_r <= 8'h00;
         o_tick <= 1'b0;
      end
      else if (cnt_r == DIV[7:0] - 8'h01)
      begin
         cnt_r <= 8'h00;
         o_tick <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + 8'h01;
         o_tick <= 1'b0;
      end
   end
endmodule // csd_quarter_div

// >>> rtl/csd_bcd_adjust.v
// Packed BCD correction of the working register
module csd_bcd_adjust
(
   input wire [7:0] i_work,
   input wire i_carry,
   input wire i_digit_carry,
   output reg [7:0] o_work,
   output reg o_carry
);
   reg [4:0] lo;
   reg [4:0] hi;

   always @*
   begin
      lo = {1'b0, i_work[3:0]};
      hi = {1'b0, i_work[7:4]} + {4'h0, i_digit_carry};
      if (lo > `CSD_BCD_MAX || i_digit_carry)
         lo = lo + `CSD_BCD_FIX;
      if (hi > `CSD_BCD_MAX || i_carry)
         hi = hi + `CSD_BCD_FIX;
      o_work = {hi[3:0], lo[3:0]};
      o_carry = i_carry | hi[4];
   end
endmodule // csd_bcd_adjust

// >>> verif/csd_exec_unit_sva.sv
// Port assertions for the compare-skip and decimal-adjust unit
`include "csd_defs.vh"
module csd_exec_unit_sva
#(
   parameter QUARTER_DIV = 1
)
(
   input wire i_clock,
   input wire i_rst_b,
   input wire i_reg_wr,
   input wire [15:0] i_instr,
   input wire o_instr_take,
   input wire o_busy,
   input wire o_mem_rd,
   input wire [3:0] o_quarter,
   input wire o_skip,
   input wire [1:0] o_skip_words,
   input wire o_nop_cycle,
   input wire o_carry
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   reg [3:0] nop_cnt_r;
   wire [3:0] nop_cnt_nxt = o_nop_cycle ? nop_cnt_r + 4'h1 : 4'h0;
   // Twelve skip cycles exceed what a repetition may unroll
   always @(posedge i_clock)
   begin
      if (!i_rst_b)
         nop_cnt_r <= 4'h0;
      else
         nop_cnt_r <= nop_cnt_nxt;
   end
   sequence s_cmp_body;
      o_busy [*3];
   endsequence
   sequence s_cmp_end;
      o_skip || !o_busy;
   endsequence
   property p_take_code;
      o_instr_take |-> $past(i_instr[15:9]) == `CSD_OPC_CMP_LT || $past(i_instr[15:9]) == `CSD_OPC_CMP_GT
         || $past(i_instr) == `CSD_OPC_DAW;
   endproperty
   property p_rd_q2;
      o_mem_rd |-> o_quarter == `CSD_Q2 && o_instr_take;
   endproperty
   property p_daw_no_rd;
      o_instr_take && $past(i_instr) == `CSD_OPC_DAW |-> !o_mem_rd ##3 !o_busy;
   endproperty
   property p_onehot;
      $onehot(o_quarter);
   endproperty
   property p_skip_nop;
      o_skip |-> o_nop_cycle && o_skip_words != 2'h0;
   endproperty
   property p_nop_len;
      !o_nop_cycle && nop_cnt_r != 4'h0 |-> nop_cnt_r == {o_skip_words, 2'h0};
   endproperty
   property p_take_idle;
      o_instr_take |-> !$past(o_busy);
   endproperty
   property p_cmp_walk;
      o_mem_rd |-> s_cmp_body ##1 s_cmp_end;
   endproperty
   property p_carry_sticky;
      o_carry && !i_reg_wr |=> o_carry;
   endproperty
   a_take_code: assert property (p_take_code) else $error("take on foreign word");
   a_rd_q2: assert property (p_rd_q2) else $error("file read outside Q2");
   a_daw_no_rd: assert property (p_daw_no_rd) else $error("adjust timing wrong");
   a_onehot: assert property (p_onehot) else $error("quarter not one-hot");
   a_skip_nop: assert property (p_skip_nop) else $error("skip without nop cycles");
   a_nop_len: assert property (p_nop_len) else $error("nop cycle count wrong");
   a_take_idle: assert property (p_take_idle) else $error("take while busy");
   a_cmp_walk: assert property (p_cmp_walk) else $error("compare walk wrong");
   a_carry_sticky: assert property (p_carry_sticky) else $error("carry cleared");
endmodule // csd_exec_unit_sva

bind csd_exec_unit csd_exec_unit_sva #(.QUARTER_DIV(QUARTER_DIV)) u_sva (.i_clock, .i_rst_b, .i_reg_wr, .i_instr,
   .o_instr_take, .o_busy, .o_mem_rd, .o_quarter, .o_skip, .o_skip_words, .o_nop_cycle, .o_carry);

// >>> verif/test_compare_skip_decimal_adjust.sv
// Self-checking bench for the execution unit
module test_compare_skip_decimal_adjust;
   timeunit 1ns;
   timeprecision 1ps;
   reg i_clock = 1'b0;
   reg i_rst_b = 1'b0;
   reg [2:0] i_reg_addr = 3'h0;
   reg [7:0] i_reg_wdata = 8'h00;
   reg i_reg_wr = 1'b0;
   reg i_reg_rd = 1'b0;
   reg i_instr_valid = 1'b0;
   reg [15:0] i_instr = 16'h0000;
   reg [1:0] i_next_words = 2'h1;
   reg [7:0] i_mem_rdata = 8'h00;
   wire [7:0] o_reg_rdata, o_work;
   wire [11:0] o_mem_addr;
   wire [3:0] o_quarter;
   wire [1:0] o_skip_words;
   wire o_instr_take, o_busy, o_mem_rd, o_skip, o_nop_cycle, o_carry;
   int seed = 46413;
   int n_errors = 0;
   int checks_done = 0;
   logic [7:0] q[$];
   reg rd_d = 1'b0;
   reg [3:0] bank = 4'h0;
   reg ext = 1'b0;
   reg [11:0] idx = 12'h000;
   reg [1:0] flg = 2'h0;
   csd_exec_unit #(.QUARTER_DIV(1)) dut_u (.i_clock, .i_rst_b, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
      .o_reg_rdata, .i_instr_valid, .i_instr, .i_next_words, .o_instr_take, .o_busy, .o_mem_addr, .o_mem_rd,
      .i_mem_rdata, .o_quarter, .o_skip, .o_skip_words, .o_nop_cycle, .o_work, .o_carry);
   always #5 i_clock = ~i_clock;
   task check(input [15:0] seen, input [15:0] exp);
   begin
      checks_done++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   // Read data stands one cycle only, so it is sampled mid-cycle
   always @(posedge i_clock) rd_d <= i_reg_rd;
   always @(negedge i_clock)
   begin
      if (rd_d === 1'b1)
         check(o_reg_rdata, q.pop_front());
   end
   task bus(input w, input [2:0] a, input [7:0] d);
   begin
      @(posedge i_clock);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      if (w)
         i_reg_wr <= 1'b1;
      else
         i_reg_rd <= 1'b1;
      if (!w)
         q.push_back(d);
      @(posedge i_clock);
      i_reg_wr <= 1'b0;
      i_reg_rd <= 1'b0;
   end
   endtask
   task exec(input [15:0] ins, input [1:0] nw, input [7:0] f, input int len);
      int n;
   begin
      @(posedge i_clock);
      i_instr <= ins;
      i_next_words <= nw;
      i_mem_rdata <= f;
      i_instr_valid <= 1'b1;
      n = 0;
      // Outputs are read at the edge, before that edge updates them
      while (o_instr_take !== 1'b1 && n < 50)
      begin
         @(posedge i_clock);
         n++;
      end
      i_instr_valid <= 1'b0;
      check(n < 50, 1);
      n = 0;
      while (o_busy === 1'b1 && n < 40)
      begin
         n++;
         @(posedge i_clock);
      end
      check(n, len);
   end
   endtask
   task cmp(input gt, input a, input [7:0] f, input [7:0] fv, input [7:0] w, input [1:0] nw);
      reg hit;
      reg [11:0] ea;
   begin
      hit = gt ? fv > w : fv < w;
      if (a)
         ea = {bank, f};
      else if (ext && f <= 8'h5F)
         ea = idx + f;
      else
         ea = {(f < 8'h60) ? 4'h0 : 4'hF, f};
      bus(1, 0, w);
      exec({5'h0C, gt, 1'b0, a, f}, nw, fv, hit ? 3 + 4 * nw : 3);
      check(o_mem_addr, ea);
      check(o_skip_words, hit ? nw : 2'h0);
      bus(0, 6, {4'h0, nw, hit, 1'b0});
      bus(0, 2, {6'h00, flg});
   end
   endtask
   task decimal_adjust_working(input [7:0] w, input dc, input c);
      reg [4:0] lo, hi;
      reg [7:0] e;
   begin
      lo = {1'b0, w[3:0]};
      if (lo > 9 || dc)
         lo = lo + 6;
      hi = w[7:4] + dc;
      if (hi > 9 || c)
         hi = hi + 6;
      e = {hi[3:0], lo[3:0]};
      flg = {dc, c | hi[4]};
      bus(1, 2, {6'h00, dc, c});
      bus(1, 0, w);
      exec(16'h0007, 1, 8'h00, 3);
      check(o_work, e);
      check(o_carry, flg[0]);
      bus(0, 0, e);
      bus(0, 2, {6'h00, flg});
   end
   endtask
   task conclude;
   begin
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask
   initial
   begin
      #400000;
      n_errors++;
      conclude;
   end
   initial
   begin : main
      reg [7:0] w;
      repeat (10) @(posedge i_clock);
      i_rst_b <= 1'b1;
      bus(1, 7, 8'h5A);
      bus(0, 7, 8'h00);
      i_instr <= 16'h6200;
      i_instr_valid <= 1'b1;
      repeat (8) @(posedge i_clock);
      check(o_instr_take, 0);
      i_instr_valid <= 1'b0;
      $display("test decode done");
      for (int i = 0; i < 24; i++)
      begin
         bank = $random(seed);
         ext = $random(seed);
         idx = $random(seed);
         bus(1, 1, {4'h0, bank});
         bus(1, 3, {7'h00, ext});
         bus(1, 4, idx[7:0]);
         bus(1, 5, {4'h0, idx[11:8]});
         w = $random(seed);
         cmp(i[0], i[1], $random(seed), (i % 4 == 0) ? w : $random(seed), w, 1 + (i / 2) % 3);
      end
      $display("test compare done");
      decimal_adjust_working(8'hA5, 0, 0);
      decimal_adjust_working(8'hCE, 0, 0);
      for (int i = 0; i < 8; i++)
         decimal_adjust_working($random(seed), i[0], i[1]);
      $display("test adjust done");
      repeat (4) @(posedge i_clock);
      conclude;
   end
endmodule // test_compare_skip_decimal_adjust
